// >>> rtl/rla_cfg_mem.sv
/*
 * eight-word store of one lane's captured configuration, one write port and a
 * registered read port. assumes one writer and one reader on the core clock.
 */
`timescale 1ns/1ps
`default_nettype none

module rla_cfg_mem
	import rla_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// write side
	input wire logic we_i,
	input wire logic [RLA_CFG_AW-1:0] waddr_i,
	input wire logic [31:0] wdata_i,
	// read side
	input wire logic re_i,
	input wire logic [RLA_CFG_AW-1:0] raddr_i,
	output logic [31:0] rdata_o
);

	typedef struct packed {
		logic [RLA_CFG_WORDS-1:0][31:0] words;
		logic [31:0] rdata;
	} rla_mem_state_type;

	rla_mem_state_type st_reg;
	rla_mem_state_type st_next;

	// read returns the old word when both ports hit the same address
	always_comb begin
		st_next = st_reg;
		if (re_i) begin
			st_next.rdata = st_reg.words[raddr_i];
		end
		if (we_i) begin
			st_next.words[waddr_i] = wdata_i;
		end
	end

	// fields reset to zero so an unlocked lane reads clean
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign rdata_o = st_reg.rdata;

endmodule
`default_nettype wire

// >>> rtl/rla_lane_capture.sv
/*
 * collects the fourteen configuration octets of one lane and, once the set is
 * complete, writes the eight packed register words into the lane store.
 * assumes octets come from the lane decoder on the core clock, first octet flagged.
 */
`timescale 1ns/1ps
`default_nettype none

module rla_lane_capture
	import rla_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// octets from the lane
	input wire logic oct_valid_i,
	input wire logic oct_first_i,
	input wire logic [7:0] oct_data_i,
	// store write port
	output logic mem_we_o,
	output logic [RLA_CFG_AW-1:0] mem_waddr_o,
	output logic [31:0] mem_wdata_o
);

	typedef logic [RLA_CFG_OCTETS-1:0][7:0] rla_octets_type;

	typedef struct packed {
		rla_octets_type collect;
		rla_octets_type snap;
		logic [3:0] idx;
		logic collecting;
		logic committing;
		logic [RLA_CFG_AW-1:0] wr_idx;
	} rla_lane_state_type;

	rla_lane_state_type st_reg;
	rla_lane_state_type st_next;
	logic done;

	// ****************************************
	// word packing
	// ****************************************
	function automatic logic [31:0] pack_word(input rla_octets_type o, input logic [RLA_CFG_AW-1:0] w);
		logic [31:0] r;
		r = '0;
		case (w)
			RLA_W_VERSION: begin
				r[RLA_F_SUBCLASS +: 3] = o[RLA_OCT_NP][RLA_O_TOP3 +: 3];
				r[RLA_F_VERSION +: 3] = o[RLA_OCT_S][RLA_O_TOP3 +: 3];
			end
			RLA_W_FRAME_OCTETS: r[RLA_F_LOW +: 8] = o[RLA_OCT_F]; // RULE_04
			RLA_W_MF_LEN: r[RLA_F_LOW +: 5] = o[RLA_OCT_K][RLA_O_LO +: 5]; // RULE_05
			RLA_W_IDENT: begin
				r[RLA_F_TOP +: 5] = o[RLA_OCT_L][RLA_O_LO +: 5]; // RULE_06
				r[RLA_F_HIGH +: 5] = o[RLA_OCT_LID][RLA_O_LO +: 5]; // RULE_07
				r[RLA_F_MID +: 4] = o[RLA_OCT_BID][RLA_O_LO +: 4]; // RULE_07
				r[RLA_F_LOW +: 8] = o[RLA_OCT_DID]; // RULE_07
			end
			RLA_W_SAMPLE: begin
				r[RLA_F_TOP +: 2] = o[RLA_OCT_N][RLA_O_TOP2 +: 2]; // RULE_08
				r[RLA_F_HIGH +: 5] = o[RLA_OCT_NP][RLA_O_LO +: 5]; // RULE_09
				r[RLA_F_MID +: 5] = o[RLA_OCT_N][RLA_O_LO +: 5]; // RULE_09
				r[RLA_F_LOW +: 8] = o[RLA_OCT_M]; // RULE_10
			end
			RLA_W_LAYOUT: begin
				r[RLA_F_TOP +: 5] = o[RLA_OCT_CF][RLA_O_LO +: 5]; // RULE_11
				r[RLA_F_HIGH] = o[RLA_OCT_CF][RLA_O_MSB]; // RULE_11
				r[RLA_F_MID +: 5] = o[RLA_OCT_S][RLA_O_LO +: 5]; // RULE_12
				r[RLA_F_LOW] = o[RLA_OCT_L][RLA_O_MSB]; // RULE_13
			end
			RLA_W_PHASE: begin
				r[RLA_F_ADJUST_DIRECTION] = o[RLA_OCT_LID][RLA_O_ADJUST_DIRECTION]; // RULE_14
				r[RLA_F_PHASE_ADJUST_REQUEST] = o[RLA_OCT_LID][RLA_O_PHASE_ADJUST_REQUEST]; // RULE_14
				r[RLA_F_LOW +: 4] = o[RLA_OCT_BID][RLA_O_NIB_HI +: 4]; // RULE_15
			end
			RLA_W_CHECK: begin
				r[RLA_F_HIGH +: 8] = o[RLA_OCT_CHK]; // RULE_17
				r[RLA_F_MID +: 8] = o[RLA_OCT_SPARE_CONFIG_OCTET_HIGH]; // RULE_18
				r[RLA_F_LOW +: 8] = o[RLA_OCT_SPARE_CONFIG_OCTET_LOW]; // RULE_18
			end
			default: r = '0;
		endcase
		return r;
	endfunction

	// ****************************************
	// collect and commit
	// ****************************************
	assign done = st_reg.collecting && oct_valid_i && !oct_first_i && (st_reg.idx == RLA_OCT_LAST);

	always_comb begin
		st_next = st_reg;
		if (oct_valid_i && oct_first_i) begin
			st_next.collect[RLA_OCT_DID] = oct_data_i; // RULE_20
			st_next.idx = 4'h1;
			st_next.collecting = 1'b1;
		end else if (oct_valid_i && st_reg.collecting) begin
			st_next.collect[st_reg.idx] = oct_data_i; // RULE_20
			st_next.idx = st_reg.idx + 4'h1;
			if (done) begin
				st_next.collecting = 1'b0;
			end
		end
		if (st_reg.committing) begin
			st_next.wr_idx = st_reg.wr_idx + 3'h1;
			if (st_reg.wr_idx == RLA_W_CHECK) begin
				st_next.committing = 1'b0;
			end
		end
		// a partial set never reaches the store; the snapshot keeps the commit stable
		if (done) begin
			st_next.snap = st_reg.collect; // RULE_22
			st_next.snap[RLA_OCT_CHK] = oct_data_i; // RULE_22
			st_next.committing = 1'b1;
			st_next.wr_idx = RLA_W_VERSION;
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign mem_we_o = st_reg.committing;
	assign mem_waddr_o = st_reg.wr_idx;
	assign mem_wdata_o = pack_word(st_reg.snap, st_reg.wr_idx);

	// ****************************************
	// checks
	// ****************************************
	commit_burst_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RULE_22
		done && !st_reg.committing |=> mem_we_o [*8] ##1 !mem_we_o || done)
		else $error("commit did not write eight words");

	frame_octets_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RULE_04
		mem_we_o && mem_waddr_o == RLA_W_FRAME_OCTETS |-> mem_wdata_o == {24'h00_0000, st_reg.snap[RLA_OCT_F]})
		else $error("frame octet word wrongly packed");

	lane_count_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RULE_06
		mem_we_o && mem_waddr_o == RLA_W_IDENT |-> mem_wdata_o[RLA_F_TOP +: 5] == st_reg.snap[RLA_OCT_L][RLA_O_LO +: 5])
		else $error("lane count field wrongly packed");

endmodule
`default_nettype wire

// >>> rtl/rla_main.sv
/*
 * per-lane status bank of the receive link: test multiframe counters and the
 * captured alignment configuration, read over an AXI4-Lite slave.
 * assumes lane decoders, test mode and multiframe pulses all run on sys_clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RULE_01: each lane counts alignment multiframes while test mode is continuous alignment.
// RULE_02: counter clears when test mode changes into continuous alignment.
// RULE_03: counter keeps its value when test mode leaves continuous alignment.
// RULE_04: octets per frame, minus one, in bits 7:0.
// RULE_05: frames per multiframe, minus one, in bits 4:0.
// RULE_06: lanes per link, minus one, in bits 28:24.
// RULE_07: lane, bank and device identifiers stored plain, reset to zero.
// RULE_08: control bits per sample plain in bits 25:24.
// RULE_09: total bits per sample 20:16, resolution 12:8, both minus one.
// RULE_10: converters per device, minus one, in bits 7:0.
// RULE_11: control words per frame 28:24 plain, high density bit 16, default zero.
// RULE_12: samples per converter per frame, minus one, bits 12:8, default zero.
// RULE_13: scrambling flag in bit 0, one when enabled, receive side only.
// RULE_14: adjust direction bit 16, phase request bit 8, adjust count 3:0, plain.
// RULE_15: adjust count shows the value captured from that very lane.
// RULE_16: transmit-side adjust count would go to every lane; not on this receiver.
// RULE_17: checksum plain in bits 23:16, default zero, never writable.
// RULE_18: the two spare configuration octets land in bits 15:8 and 7:0.
// RULE_19: every lane owns its own counter and configuration copy.
// RULE_20: each lane's alignment configuration is captured and readable.
// RULE_21: software reads these registers over an AXI4-Lite interface.
// RULE_22: captured fields change only on a complete configuration multiframe.
module rla_main
	import rla_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// link side
	input wire logic [2:0] test_mode_i,
	input wire logic [RLA_LANES-1:0] lane_ila_mf_i,
	input wire logic [RLA_LANES-1:0] lane_oct_valid_i,
	input wire logic [RLA_LANES-1:0] lane_oct_first_i,
	input wire logic [RLA_LANES-1:0][7:0] lane_oct_data_i,
	// AXI4-Lite write address and data
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [RLA_ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	// AXI4-Lite write response
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	output logic [1:0] s_axi_bresp_o,
	// AXI4-Lite read
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	input wire logic [RLA_ADDR_W-1:0] s_axi_araddr_i,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o
);

	// ****************************************
	// types and state
	// ****************************************
	typedef enum logic [1:0] {
		RLA_BUS_IDLE = 2'b00,
		RLA_BUS_FETCH = 2'b01,
		RLA_BUS_RDATA = 2'b10,
		RLA_BUS_BRESP = 2'b11
	} rla_bus_type;

	typedef struct packed {
		rla_bus_type bus;
		logic [RLA_LANES-1:0][31:0] mf_count;
		logic [2:0] mode_prev;
		logic [RLA_LANE_W-1:0] rd_lane;
		logic rd_count;
		logic rd_err;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [1:0] bresp;
	} rla_main_state_type;

	rla_main_state_type st_reg;
	rla_main_state_type st_next;

	logic ar_take;
	logic aw_take;
	logic enter_test;
	logic in_test;
	logic [RLA_CFG_AW-1:0] rd_word;
	logic [RLA_LANES-1:0] mem_we;
	logic [RLA_LANES-1:0][RLA_CFG_AW-1:0] mem_waddr;
	logic [RLA_LANES-1:0][31:0] mem_wdata;
	logic [RLA_LANES-1:0][31:0] mem_rdata;

	// ****************************************
	// address decode
	// ****************************************
	function automatic logic addr_mapped(input logic [RLA_ADDR_W-1:0] a);
		logic ok;
		ok = (a[RLA_ADDR_W-1 -: 3] == RLA_TOP_ZERO) && (a[RLA_WORD_LSB +: 4] <= RLA_WORD_CFG_LAST);
		return ok;
	endfunction

	function automatic logic [3:0] addr_word(input logic [RLA_ADDR_W-1:0] a);
		return a[RLA_WORD_LSB +: 4];
	endfunction

	// ****************************************
	// per-lane capture and store
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < RLA_LANES; g++) begin : g_lane // RULE_19
			rla_lane_capture u_capture (
				.sys_clk_i(sys_clk_i),
				.resetn_i(resetn_i),
				.oct_valid_i(lane_oct_valid_i[g]),
				.oct_first_i(lane_oct_first_i[g]),
				.oct_data_i(lane_oct_data_i[g]),
				.mem_we_o(mem_we[g]),
				.mem_waddr_o(mem_waddr[g]),
				.mem_wdata_o(mem_wdata[g])
			);
			rla_cfg_mem u_mem (
				.sys_clk_i(sys_clk_i),
				.resetn_i(resetn_i),
				.we_i(mem_we[g]),
				.waddr_i(mem_waddr[g]),
				.wdata_i(mem_wdata[g]),
				.re_i(ar_take),
				.raddr_i(rd_word),
				.rdata_o(mem_rdata[g])
			);
		end
	endgenerate

	// ****************************************
	// bus handshakes
	// ****************************************
	// reads win over a write offered in the same cycle
	assign s_axi_arready_o = (st_reg.bus == RLA_BUS_IDLE);
	assign ar_take = s_axi_arvalid_i && s_axi_arready_o; // RULE_21
	assign aw_take = (st_reg.bus == RLA_BUS_IDLE) && !s_axi_arvalid_i && s_axi_awvalid_i && s_axi_wvalid_i;
	assign s_axi_awready_o = aw_take;
	assign s_axi_wready_o = aw_take;
	assign s_axi_rvalid_o = (st_reg.bus == RLA_BUS_RDATA);
	assign s_axi_bvalid_o = (st_reg.bus == RLA_BUS_BRESP);
	assign s_axi_rdata_o = st_reg.rdata;
	assign s_axi_rresp_o = st_reg.rresp;
	assign s_axi_bresp_o = st_reg.bresp;
	// store word index is the register word less the counter slot
	assign rd_word = RLA_CFG_AW'(addr_word(s_axi_araddr_i) - 4'h1);

	assign in_test = (test_mode_i == RLA_MODE_CONT_ILA);
	assign enter_test = in_test && (st_reg.mode_prev != RLA_MODE_CONT_ILA);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		st_next = st_reg;
		st_next.mode_prev = test_mode_i;

		for (int i = 0; i < RLA_LANES; i++) begin
			if (enter_test) begin
				st_next.mf_count[i] = '0; // RULE_02
			end else if (in_test && lane_ila_mf_i[i]) begin
				st_next.mf_count[i] = st_reg.mf_count[i] + 32'h0000_0001; // RULE_01
			end
			// outside the test mode the count simply holds
		end // RULE_03

		case (st_reg.bus)
			RLA_BUS_IDLE: begin
				if (ar_take) begin
					st_next.rd_lane = s_axi_araddr_i[RLA_LANE_LSB +: RLA_LANE_W];
					st_next.rd_count = (addr_word(s_axi_araddr_i) == RLA_WORD_COUNT);
					st_next.rd_err = !addr_mapped(s_axi_araddr_i);
					st_next.bus = RLA_BUS_FETCH;
				end else if (aw_take) begin
					// every register here is read-only on a receiver; writes leave no trace
					st_next.bresp = addr_mapped(s_axi_awaddr_i) ? RLA_RESP_OKAY : RLA_RESP_DECERR; // RULE_13 RULE_16 RULE_17
					st_next.bus = RLA_BUS_BRESP;
				end
			end
			RLA_BUS_FETCH: begin
				if (st_reg.rd_err) begin
					st_next.rdata = '0;
					st_next.rresp = RLA_RESP_DECERR;
				end else if (st_reg.rd_count) begin
					st_next.rdata = st_reg.mf_count[st_reg.rd_lane]; // RULE_21
					st_next.rresp = RLA_RESP_OKAY;
				end else begin
					st_next.rdata = mem_rdata[st_reg.rd_lane]; // RULE_20
					st_next.rresp = RLA_RESP_OKAY;
				end
				st_next.bus = RLA_BUS_RDATA;
			end
			RLA_BUS_RDATA: begin
				if (s_axi_rready_i) begin
					st_next.bus = RLA_BUS_IDLE;
				end
			end
			RLA_BUS_BRESP: begin
				if (s_axi_bready_i) begin
					st_next.bus = RLA_BUS_IDLE;
				end
			end
			default: st_next.bus = RLA_BUS_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	generate
		for (g = 0; g < RLA_LANES; g++) begin : g_chk
			cnt_clear_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RULE_02
				enter_test |=> st_reg.mf_count[g] == 32'h0000_0000)
				else $error("test counter not cleared on entry");

			cnt_incr_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RULE_01
				in_test && !enter_test && lane_ila_mf_i[g]
				|=> st_reg.mf_count[g] == $past(st_reg.mf_count[g]) + 32'h0000_0001)
				else $error("test counter missed a multiframe");

			cnt_hold_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RULE_03
				!in_test |=> $stable(st_reg.mf_count[g]))
				else $error("test counter moved outside test mode");
		end
	endgenerate

	rd_latency_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RULE_21
		ar_take |-> !s_axi_rvalid_o ##1 !s_axi_rvalid_o ##1 s_axi_rvalid_o)
		else $error("read answer not two cycles after address");

	rdata_hold_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RULE_21
		s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read data dropped before accept");

	wr_answer_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i) // RULE_17
		aw_take |=> s_axi_bvalid_o && (s_axi_bresp_o == ($past(addr_mapped(s_axi_awaddr_i)) ? RLA_RESP_OKAY : RLA_RESP_DECERR)))
		else $error("write answer missing or wrong");

endmodule
`default_nettype wire

// >>> rtl/rla_pkg.sv
/*
 * shared constants for the receive lane-alignment capture bank:
 * lane count, register map, field positions and bus answer codes.
 * assumes the octets of the alignment configuration arrive in their standard order.
 */
package rla_pkg;

	// ****************************************
	// sizes
	// ****************************************
	localparam int unsigned RLA_LANES = 8;
	localparam int unsigned RLA_LANE_W = 3;
	localparam int unsigned RLA_ADDR_W = 12;
	localparam int unsigned RLA_CFG_OCTETS = 14;
	localparam int unsigned RLA_CFG_WORDS = 8;
	localparam int unsigned RLA_CFG_AW = 3;
	localparam logic [3:0] RLA_OCT_LAST = 4'hd;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam int unsigned RLA_LANE_LSB = 6;
	localparam int unsigned RLA_WORD_LSB = 2;
	localparam logic [3:0] RLA_WORD_COUNT = 4'h0;
	localparam logic [3:0] RLA_WORD_CFG_LAST = 4'h8;
	localparam logic [2:0] RLA_TOP_ZERO = 3'h0;

	// word index inside the capture memory
	localparam logic [2:0] RLA_W_VERSION = 3'h0;
	localparam logic [2:0] RLA_W_FRAME_OCTETS = 3'h1;
	localparam logic [2:0] RLA_W_MF_LEN = 3'h2;
	localparam logic [2:0] RLA_W_IDENT = 3'h3;
	localparam logic [2:0] RLA_W_SAMPLE = 3'h4;
	localparam logic [2:0] RLA_W_LAYOUT = 3'h5;
	localparam logic [2:0] RLA_W_PHASE = 3'h6;
	localparam logic [2:0] RLA_W_CHECK = 3'h7;

	// ****************************************
	// test mode
	// ****************************************
	localparam logic [2:0] RLA_MODE_CONT_ILA = 3'h2;

	// ****************************************
	// octet positions in the configuration multiframe
	// ****************************************
	localparam int unsigned RLA_OCT_DID = 0;
	localparam int unsigned RLA_OCT_BID = 1;
	localparam int unsigned RLA_OCT_LID = 2;
	localparam int unsigned RLA_OCT_L = 3;
	localparam int unsigned RLA_OCT_F = 4;
	localparam int unsigned RLA_OCT_K = 5;
	localparam int unsigned RLA_OCT_M = 6;
	localparam int unsigned RLA_OCT_N = 7;
	localparam int unsigned RLA_OCT_NP = 8;
	localparam int unsigned RLA_OCT_S = 9;
	localparam int unsigned RLA_OCT_CF = 10;
	localparam int unsigned RLA_OCT_SPARE_CONFIG_OCTET_LOW = 11;
	localparam int unsigned RLA_OCT_SPARE_CONFIG_OCTET_HIGH = 12;
	localparam int unsigned RLA_OCT_CHK = 13;
	// sub-fields inside an octet
	localparam int unsigned RLA_O_LO = 0;
	localparam int unsigned RLA_O_NIB_HI = 4;
	localparam int unsigned RLA_O_TOP3 = 5;
	localparam int unsigned RLA_O_PHASE_ADJUST_REQUEST = 5;
	localparam int unsigned RLA_O_ADJUST_DIRECTION = 6;
	localparam int unsigned RLA_O_TOP2 = 6;
	localparam int unsigned RLA_O_MSB = 7;

	// ****************************************
	// register field positions
	// ****************************************
	localparam int unsigned RLA_F_SUBCLASS = 0;
	localparam int unsigned RLA_F_VERSION = 8;
	localparam int unsigned RLA_F_LOW = 0;
	localparam int unsigned RLA_F_MID = 8;
	localparam int unsigned RLA_F_HIGH = 16;
	localparam int unsigned RLA_F_TOP = 24;
	localparam int unsigned RLA_F_ADJUST_DIRECTION = 16;
	localparam int unsigned RLA_F_PHASE_ADJUST_REQUEST = 8;

	// ****************************************
	// bus answers
	// ****************************************
	localparam logic [1:0] RLA_RESP_OKAY = 2'h0;
	localparam logic [1:0] RLA_RESP_DECERR = 2'h3;

endpackage

// >>> verif/rla_conv_model.sv
/*
 * converter-side model: sends alignment configuration octets and multiframe pulses per lane.
 * assumes the bench calls its tasks and shares the core clock; drives on the falling edge.
 */
`timescale 1ns/1ps
`default_nettype none

module rla_conv_model
	import rla_pkg::*;
(
	// core clock
	input wire logic sys_clk_i,
	// lane side
	output logic [RLA_LANES-1:0] lane_ila_mf_o,
	output logic [RLA_LANES-1:0] lane_oct_valid_o,
	output logic [RLA_LANES-1:0] lane_oct_first_o,
	output logic [RLA_LANES-1:0][7:0] lane_oct_data_o
);
	initial begin
		lane_ila_mf_o = '0;
		lane_oct_valid_o = '0;
		lane_oct_first_o = '0;
		lane_oct_data_o = '0;
	end

	// n below 14 leaves a partial set; slow puts an idle cycle between octets
	task automatic send_set(input int lane, input logic [13:0][7:0] oct, input int n, input bit slow);
		for (int i = 0; i < n; i++) begin
			@(negedge sys_clk_i);
			lane_oct_valid_o[lane] = 1'b1;
			lane_oct_first_o[lane] = (i == 0);
			lane_oct_data_o[lane] = oct[i];
			if (slow) begin
				@(negedge sys_clk_i);
				lane_oct_valid_o[lane] = 1'b0;
				lane_oct_data_o[lane] = ~oct[i];
			end
		end
		@(negedge sys_clk_i);
		lane_oct_valid_o[lane] = 1'b0;
		lane_oct_first_o[lane] = 1'b0;
		// idle line inverts what it held: the last octet's inverse after a fast set, the last octet itself after a slow one
		lane_oct_data_o[lane] = ~lane_oct_data_o[lane];
	endtask

	task automatic pulse_mf(input logic [RLA_LANES-1:0] mask, input int n);
		repeat (n) begin
			@(negedge sys_clk_i);
			lane_ila_mf_o = mask;
			@(negedge sys_clk_i);
			lane_ila_mf_o = '0;
		end
	endtask
endmodule

`default_nettype wire

// >>> verif/rla_main_tb.sv
/*
 * self-checking bench of the lane status bank: register reads, capture per lane, test counter.
 * assumes the converter model drives the lanes; the bench is the bus master.
 */
`timescale 1ns/1ps
`default_nettype none

module rla_main_tb;
	import rla_pkg::*;
	logic clk = 1'b0;
	logic rstn;
	logic [2:0] mode;
	logic [7:0] mf, ov, of;
	logic [7:0][7:0] od;
	logic awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
	logic [11:0] awa, ara;
	logic [31:0] wd, rd;
	logic [3:0] ws;
	logic [1:0] bresp, rresp;
	logic [33:0] exp_q[$];
	logic [13:0][7:0] oct [8];
	logic [31:0] seed = 32'ha995;
	int n_fail = 0;
	int samples_checked = 0;

	always #10 clk = ~clk;

	rla_main u_dut (.sys_clk_i(clk), .resetn_i(rstn), .test_mode_i(mode), .lane_ila_mf_i(mf),
		.lane_oct_valid_i(ov), .lane_oct_first_i(of), .lane_oct_data_i(od),
		.s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv),
		.s_axi_wready_o(wr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_bvalid_o(bv),
		.s_axi_bready_i(br), .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
		.s_axi_araddr_i(ara), .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .s_axi_rdata_o(rd),
		.s_axi_rresp_o(rresp));

	rla_conv_model u_conv (.sys_clk_i(clk), .lane_ila_mf_o(mf), .lane_oct_valid_o(ov),
		.lane_oct_first_o(of), .lane_oct_data_o(od));

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	function automatic logic [31:0] cfgw(input logic [13:0][7:0] o, input int k);
		case (k)
			0: return {21'h0, o[9][7:5], 5'h0, o[8][7:5]};
			1: return {24'h0, o[4]};
			2: return {27'h0, o[5][4:0]};
			3: return {3'h0, o[3][4:0], 3'h0, o[2][4:0], 4'h0, o[1][3:0], o[0]};
			4: return {6'h0, o[7][7:6], 3'h0, o[8][4:0], 3'h0, o[7][4:0], o[6]};
			5: return {3'h0, o[10][4:0], 7'h0, o[10][7], 3'h0, o[9][4:0], 7'h0, o[3][7]};
			6: return {15'h0, o[2][6], 7'h0, o[2][5], 4'h0, o[1][7:4]};
			default: return {8'h0, o[13], o[12], o[11]};
		endcase
	endfunction

	task automatic check(input logic [33:0] seen, input logic [33:0] want);
		samples_checked++;
		if (seen !== want) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
		end
	endtask

	task automatic final_report;
		$display("checked %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// request held from a falling edge until the rising edge that samples ready
	task automatic req(input bit w, input logic [11:0] a, input logic [33:0] e);
		int k;
		exp_q.push_back(e);
		@(negedge clk);
		seed = lfsr(seed);
		if (w) begin
			awv = 1'b1;
			wv = 1'b1;
			awa = a;
			wd = seed;
			ws = seed[3:0];
		end else begin
			arv = 1'b1;
			ara = a;
		end
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (!(w ? awr : arr) && k < 20);
		@(negedge clk);
		arv = 1'b0;
		awv = 1'b0;
		wv = 1'b0;
		// rready sometimes drops for the first answer cycle, so a held read answer gets exercised
		while (exp_q.size() != 0 && k < 40) begin
			@(posedge clk);
			k++;
			@(negedge clk);
			rr = (k != 2) || seed[5];
		end
		if (k >= 40 || exp_q.size() != 0) begin
			n_fail++;
			final_report();
		end
	endtask

	// ****************************************
	// response watcher
	// ****************************************
	always @(posedge clk) begin
		if (rstn && rv && rr && exp_q.size() != 0) check({rresp, rd}, exp_q.pop_front());
		if (rstn && bv && br && exp_q.size() != 0) check({bresp, 32'h0}, exp_q.pop_front());
		if (rstn && awr) check({33'h0, wr}, 34'h1);
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		{rstn, mode, awv, wv, arv, awa, ara, wd, ws} = '0;
		rr = 1'b1;
		br = 1'b1;
		repeat (16) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		for (int w = 0; w < 9; w++) req(0, 12'(448 + w * 4), {RLA_RESP_OKAY, 32'h0});
		req(0, 12'h024, {RLA_RESP_DECERR, 32'h0});
		req(0, 12'h200, {RLA_RESP_DECERR, 32'h0});
		req(1, 12'h3f0, {RLA_RESP_DECERR, 32'h0});
		for (int l = 0; l < 8; l++) begin
			for (int i = 0; i < 14; i++) begin
				seed = lfsr(seed);
				oct[l][i] = seed[7:0];
			end
			u_conv.send_set(l, oct[l], 14, l[0]);
		end
		repeat (12) @(posedge clk);
		for (int l = 0; l < 8; l++)
			for (int w = 1; w < 9; w++)
				req(0, 12'(l * 64 + w * 4), {RLA_RESP_OKAY, cfgw(oct[l], w - 1)});
		// cut-off set and a write must both leave lane 2 as it was
		u_conv.send_set(2, ~oct[2], 9, 0);
		repeat (12) @(posedge clk);
		req(1, 12'h09c, {RLA_RESP_OKAY, 32'h0});
		for (int w = 1; w < 9; w++) req(0, 12'(128 + w * 4), {RLA_RESP_OKAY, cfgw(oct[2], w - 1)});
		// pulse in the entry cycle itself is not counted
		fork
			begin
				@(negedge clk);
				mode = RLA_MODE_CONT_ILA;
			end
			u_conv.pulse_mf(8'h08, 1);
		join
		u_conv.pulse_mf(8'h28, 3);
		u_conv.pulse_mf(8'h08, 2);
		req(0, 12'h0c0, {RLA_RESP_OKAY, 32'h5});
		req(0, 12'h140, {RLA_RESP_OKAY, 32'h3});
		@(negedge clk);
		seed = lfsr(seed);
		mode = {seed[2], 1'b0, seed[0]};
		u_conv.pulse_mf(8'h08, 4);
		req(0, 12'h0c0, {RLA_RESP_OKAY, 32'h5});
		fork
			begin
				@(negedge clk);
				mode = RLA_MODE_CONT_ILA;
			end
			u_conv.pulse_mf(8'h08, 1);
		join
		u_conv.pulse_mf(8'hff, 1);
		req(0, 12'h0c0, {RLA_RESP_OKAY, 32'h1});
		req(0, 12'h1c0, {RLA_RESP_OKAY, 32'h1});
		final_report();
	end
endmodule

`default_nettype wire
